//--- rtl/buck_softstart_spread_ctrl.sv
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "buck_ctrl_defines.svh"
// Function
// - boot undervoltage: lower switch recharge before upper
// - spread spectrum is a build-time option
// - spread band is plus/minus two percent
// - LFSR hops per cycle, bounded step
// - hop sequence repeats below 1.5 Hz
// - dropout slowing disables spread spectrum
// - auto light-load slowing disables spread; forced keeps
// - minimum on-time slowing disables spread spectrum
// - external sync lock disables spread spectrum
// - four events trigger soft start
// - reference ramps, 90% at soft-start time
// - soft start forces auto, diode emulation
// - forced mode, hiccup inhibited until regulation/timer
// - recovery sets reference 1% above output
// - hiccup off in dropout, allowed below 0.4
// - forced mode permitted during recovery
// - hiccup after >128 cycles below 0.4
// - recovery climbs at soft-start ramp rate
// - sync qualified 2048 edges before switching
module buck_softstart_spread_ctrl #(
	parameter int SOFT_START_RELEASE_CYC = `SOFT_START_RELEASE_US * 1000 / `CLK_NS,
	parameter int HICCUP_WAIT_CYC = `HICCUP_WAIT_US * 1000 / `CLK_NS
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic bootstrap_capacitor_node_low,
	input wire logic out_low,
	input wire logic out_below_40,
	input wire logic dropout,
	input wire logic min_on_time,
	input wire logic light_load,
	input wire logic sync_edge,
	input wire logic in_regulation,
	input wire logic pwm_on,
	input wire logic zero_cross,
	input wire logic uvlo_ok,
	input wire logic en,
	input wire logic thermal_ok,
	input wire logic [9:0] out_level,
	output logic upper_switch,
	output logic lower_switch,
	output logic cycle_start,
	output logic [9:0] ref_code,
	output logic diode_emulation,
	output logic forced_pulse_width_mode,
	output logic spread_active,
	output logic clock_locked,
	output logic hiccup_active,
	output logic soft_start_active,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	localparam int NSYNC = 23;
	localparam logic [9:0] REF_FULL = 10'(`REF_TARGET);
	localparam logic signed [5:0] SPREAD_MAX = 6'(`SPREAD_MAX_CYC);

	buck_ctrl_pkg::state_e state, next_state;
	logic [NSYNC-1:0] raw, s2;
	logic boot_uv_s, out_low_s, below40_s, dropout_s, min_on_s, light_s, sync_s, in_reg_s;
	logic pwm_s, zc_s, uvlo_s, en_s, therm_s;
	logic [9:0] out_level_s;

	// Analog flags arrive asynchronously; out_level is assumed slow moving
	assign raw = {bootstrap_capacitor_node_low, out_low, out_below_40, dropout, min_on_time,
		light_load, sync_edge, in_regulation, pwm_on, zero_cross, uvlo_ok, en, thermal_ok,
		out_level};
	assign {boot_uv_s, out_low_s, below40_s, dropout_s, min_on_s, light_s, sync_s, in_reg_s,
		pwm_s, zc_s, uvlo_s, en_s, therm_s, out_level_s} = s2;

	// Two-flop synchroniser per input bit
	generate
		for (genvar gi = 0; gi < NSYNC; gi++) begin : g_sync
			logic f1, f2;
			always_ff @(posedge sys_clk or negedge nrst) begin
				if (!nrst) begin
					f1 <= 1'b0;
					f2 <= 1'b0;
				end else begin
					f1 <= raw[gi];
					f2 <= f1;
				end
			end
			assign s2[gi] = f2;
		end
	endgenerate

	logic active, active_d, sync_d, sync_rise, ss_trigger, hiccup_end;
	logic running, tick, slowed, next_spread, hiccup_allowed, hiccup_trip;
	logic ss_done, ctrl_forced, next_forced, step, recharge;
	logic [19:0] tmr, lfsr;
	logic [9:0] step_cnt;
	logic [7:0] hc_cnt;
	logic [11:0] qual_cnt;
	logic [10:0] lost_cnt, per_cnt, period_m1;
	logic [4:0] rech_cnt;
	logic signed [5:0] hop_off, hop_d, hop_sum, next_hop;
	logic [10:0] rsum;
	logic [9:0] recov_ref, next_ref;
	logic next_upper, next_lower;

	// Start-up events: supply, enable, thermal recovery, end of hiccup wait
	assign active = uvlo_s & en_s & therm_s;
	assign sync_rise = sync_s & ~sync_d;
	assign hiccup_end = (state == buck_ctrl_pkg::ST_HICCUP) && (tmr == 20'(HICCUP_WAIT_CYC - 1));
	assign ss_trigger = (active & ~active_d) | hiccup_end;
	assign running = (state == buck_ctrl_pkg::ST_SOFT) || (state == buck_ctrl_pkg::ST_RUN) ||
		(state == buck_ctrl_pkg::ST_RECOVER);
	assign ss_done = in_reg_s || (tmr == 20'(SOFT_START_RELEASE_CYC - 1));

	// Hiccup only outside soft start and never in dropout regulation
	assign hiccup_allowed = ((state == buck_ctrl_pkg::ST_RUN) ||
		(state == buck_ctrl_pkg::ST_RECOVER)) && !dropout_s;
	assign hiccup_trip = tick && hiccup_allowed && below40_s &&
		(hc_cnt == 8'(`HICCUP_COUNT));

	// Sequencer
	always_comb begin
		next_state = state;
		case (state)
			buck_ctrl_pkg::ST_OFF: if (ss_trigger) next_state = buck_ctrl_pkg::ST_SOFT;
			buck_ctrl_pkg::ST_SOFT: if (ss_done) next_state = buck_ctrl_pkg::ST_RUN;
			buck_ctrl_pkg::ST_RUN: begin
				if (hiccup_trip) next_state = buck_ctrl_pkg::ST_HICCUP;
				else if (out_low_s) next_state = buck_ctrl_pkg::ST_RECOVER;
			end
			buck_ctrl_pkg::ST_RECOVER: begin
				if (hiccup_trip) next_state = buck_ctrl_pkg::ST_HICCUP;
				else if (!out_low_s && ref_code == REF_FULL) next_state = buck_ctrl_pkg::ST_RUN;
			end
			buck_ctrl_pkg::ST_HICCUP: if (hiccup_end) next_state = buck_ctrl_pkg::ST_SOFT;
			default: next_state = buck_ctrl_pkg::ST_OFF;
		endcase
		if (!active) next_state = buck_ctrl_pkg::ST_OFF;
	end

	// State, event edges and state timer
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state <= buck_ctrl_pkg::ST_OFF;
			active_d <= 1'b0;
			sync_d <= 1'b0;
			tmr <= 20'h00000;
		end else begin
			state <= next_state;
			active_d <= active;
			sync_d <= sync_s;
			tmr <= (next_state != state) ? 20'h00000 : tmr + 20'h00001;
		end
	end

	// Reference ramp; one code per step keeps start-up and recovery equal
	assign step = (step_cnt == 10'(`SS_STEP_CYC - 1));
	assign rsum = {1'b0, out_level_s} + 11'(out_level_s / 10'(`RECOV_MARGIN_DIV));
	assign recov_ref = (rsum > {1'b0, REF_FULL}) ? REF_FULL : rsum[9:0];

	always_comb begin
		next_ref = ref_code;
		case (state)
			buck_ctrl_pkg::ST_SOFT: if (step && ref_code < REF_FULL) next_ref = ref_code + 10'h001;
			buck_ctrl_pkg::ST_RUN: next_ref = out_low_s ? recov_ref : REF_FULL;
			buck_ctrl_pkg::ST_RECOVER: begin
				if (out_low_s) next_ref = recov_ref;
				else if (step && ref_code < REF_FULL) next_ref = ref_code + 10'h001;
			end
			default: next_ref = 10'h000;
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			step_cnt <= 10'h000;
			ref_code <= 10'h000;
		end else begin
			step_cnt <= step ? 10'h000 : step_cnt + 10'h001;
			ref_code <= next_ref;
		end
	end

	// Soft start forces auto mode with diode emulation; recovery keeps forced mode
	assign next_forced = ctrl_forced && running && (state != buck_ctrl_pkg::ST_SOFT);

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			forced_pulse_width_mode <= 1'b0;
			diode_emulation <= 1'b1;
			hiccup_active <= 1'b0;
			soft_start_active <= 1'b0;
		end else begin
			forced_pulse_width_mode <= next_forced;
			diode_emulation <= !next_forced;
			hiccup_active <= (next_state == buck_ctrl_pkg::ST_HICCUP);
			soft_start_active <= (next_state == buck_ctrl_pkg::ST_SOFT);
		end
	end

	// Consecutive low-output cycle count, cleared on any good cycle
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			hc_cnt <= 8'h00;
		end else if (!hiccup_allowed) begin
			hc_cnt <= 8'h00;
		end else if (tick) begin
			hc_cnt <= (below40_s && !hiccup_trip) ? hc_cnt + 8'h01 : 8'h00;
		end
	end

	// Sync qualification; a gap longer than the lost time restarts it
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			qual_cnt <= 12'h000;
			lost_cnt <= 11'h000;
			clock_locked <= 1'b0;
		end else if (sync_rise) begin
			lost_cnt <= 11'h000;
			if (qual_cnt != 12'(`SYNC_QUAL_EDGES - 1)) qual_cnt <= qual_cnt + 12'h001;
			else clock_locked <= 1'b1;
		end else if (lost_cnt == 11'(`SYNC_LOST_CYC - 1)) begin
			qual_cnt <= 12'h000;
			clock_locked <= 1'b0;
		end else begin
			lost_cnt <= lost_cnt + 11'h001;
		end
	end

	// Any slowed clock or external lock stops hopping
	assign slowed = dropout_s | min_on_s | (light_s & ~forced_pulse_width_mode);
	assign next_spread = `SPREAD_OPTION && running && !slowed && !clock_locked;

	// Period: nominal plus hop offset, or stretched when slowed
	assign period_m1 = slowed ? 11'(`NOM_PERIOD_CYC * `SLOW_FACTOR - 1) :
		11'(`NOM_PERIOD_CYC - 1) + 11'(hop_off);
	assign tick = clock_locked ? sync_rise : (per_cnt >= period_m1);

	// LFSR picks a step of -2,-1,+1,+2; band edges reflect the step
	assign hop_d = lfsr[1] ? (lfsr[0] ? 6'sd2 : 6'sd1) : (lfsr[0] ? -6'sd2 : -6'sd1);
	assign hop_sum = hop_off + hop_d;
	assign next_hop = (hop_sum > SPREAD_MAX || hop_sum < -SPREAD_MAX) ?
		hop_off - hop_d : hop_sum;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			per_cnt <= 11'h000;
			cycle_start <= 1'b0;
			spread_active <= 1'b0;
			hop_off <= 6'sd0;
			lfsr <= `LFSR_SEED;
		end else begin
			per_cnt <= tick ? 11'h000 : per_cnt + 11'h001;
			cycle_start <= tick;
			spread_active <= next_spread;
			if (!next_spread) begin
				hop_off <= 6'sd0;
			end else if (tick) begin
				hop_off <= next_hop;
				// 20-bit maximal sequence: repeat well under 1.5 Hz at nominal rate
				lfsr <= {lfsr[18:0], lfsr[19] ^ lfsr[16]};
			end
		end
	end

	// Boot recharge: lower switch on first, upper switch held off meanwhile
	assign recharge = (rech_cnt != 5'h00);
	assign next_upper = running && pwm_s && !recharge && !boot_uv_s;
	assign next_lower = running && !next_upper && (recharge || boot_uv_s ||
		!(diode_emulation && zc_s));

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rech_cnt <= 5'h00;
			upper_switch <= 1'b0;
			lower_switch <= 1'b0;
		end else begin
			if (boot_uv_s) rech_cnt <= 5'(`BOOT_CHG_CYC);
			else if (recharge) rech_cnt <= rech_cnt - 5'h01;
			upper_switch <= next_upper;
			lower_switch <= next_lower;
		end
	end

	// AXI4-Lite slave; write address and data are taken together
	logic wr_go, rd_go, wr_ctrl, wr_ro;
	logic [31:0] rd_word;
	logic rd_hit;
	assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign rd_go = s_axi_arvalid && !s_axi_rvalid;
	assign s_axi_arready = rd_go;
	assign wr_ctrl = (s_axi_awaddr == `ADDR_CTRL);
	assign wr_ro = (s_axi_awaddr == `ADDR_STATUS) || (s_axi_awaddr == `ADDR_REF);
	assign rd_hit = (s_axi_araddr == `ADDR_CTRL) || (s_axi_araddr == `ADDR_STATUS) ||
		(s_axi_araddr == `ADDR_REF);
	assign rd_word = (s_axi_araddr == `ADDR_CTRL) ? {31'h00000000, ctrl_forced} :
		(s_axi_araddr == `ADDR_STATUS) ? {24'h000000, clock_locked, spread_active,
			forced_pulse_width_mode, diode_emulation, 1'b0, 3'(state)} :
		(s_axi_araddr == `ADDR_REF) ? {16'h0000, 2'h0, hop_off, hc_cnt} :
		32'h00000000;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_forced <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else if (wr_go) begin
			if (wr_ctrl && s_axi_wstrb[0]) ctrl_forced <= s_axi_wdata[`CTRL_FORCED_BIT];
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (wr_ctrl || wr_ro) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	property p_boot_first;
		$rose(upper_switch) |-> !$past(boot_uv_s) && !$past(recharge);
	endproperty
	a_boot_first: assert property (p_boot_first) else $error("upper on during recharge");

	property p_dropout_spread;
		dropout_s |=> !spread_active;
	endproperty
	a_dropout_spread: assert property (p_dropout_spread) else $error("spread in dropout");

	property p_lock_spread;
		clock_locked |=> !spread_active && hop_off == 6'sd0;
	endproperty
	a_lock_spread: assert property (p_lock_spread) else $error("spread while locked");

	property p_hop_band;
		(hop_off <= SPREAD_MAX) && (hop_off >= -SPREAD_MAX) && (!spread_active ||
			((hop_off - $past(hop_off) <= 6'sd2) && ($past(hop_off) - hop_off <= 6'sd2)));
	endproperty
	a_hop_band: assert property (p_hop_band) else $error("hop out of band");

	property p_soft_auto;
		state == buck_ctrl_pkg::ST_SOFT |=> diode_emulation && !forced_pulse_width_mode;
	endproperty
	a_soft_auto: assert property (p_soft_auto) else $error("forced mode in soft start");

	property p_hiccup_count;
		$rose(state == buck_ctrl_pkg::ST_HICCUP) |-> $past(hc_cnt) == 8'(`HICCUP_COUNT);
	endproperty
	a_hiccup_count: assert property (p_hiccup_count) else $error("hiccup count wrong");

	property p_count_clear;
		tick && !below40_s |=> hc_cnt == 8'h00;
	endproperty
	a_count_clear: assert property (p_count_clear) else $error("count not cleared");

	property p_lock_qual;
		$rose(clock_locked) |-> $past(qual_cnt) == 12'(`SYNC_QUAL_EDGES - 1) && $past(sync_rise);
	endproperty
	a_lock_qual: assert property (p_lock_qual) else $error("lock before qualification");

	property p_no_hiccup_dropout;
		dropout_s |-> !hiccup_allowed ##1 state != buck_ctrl_pkg::ST_HICCUP || !$rose(hiccup_active);
	endproperty
	a_no_hiccup_dropout: assert property (p_no_hiccup_dropout) else $error("hiccup in dropout");

	property p_ramp_rate;
		state == buck_ctrl_pkg::ST_SOFT && $past(state == buck_ctrl_pkg::ST_SOFT) |->
			ref_code - $past(ref_code) <= 10'h001;
	endproperty
	a_ramp_rate: assert property (p_ramp_rate) else $error("ramp too fast");

endmodule

//--- rtl/buck_ctrl_defines.svh
`ifndef BUCK_CTRL_DEFINES_SVH
`define BUCK_CTRL_DEFINES_SVH

// System clock
`define CLK_NS 10

// Spread spectrum build option, fixed at build time
`define SPREAD_OPTION 1'b1

// Switching clock
`define NOM_FREQ_KHZ 400
`define NOM_PERIOD_CYC (1000000 / (`NOM_FREQ_KHZ * `CLK_NS))
`define SPREAD_PCT 2
`define SPREAD_MAX_CYC (`NOM_PERIOD_CYC * `SPREAD_PCT / 100)
`define HOP_MAX_STEP 2
`define SLOW_FACTOR 4
`define LFSR_SEED 20'h00001

// External synchronisation
`define SYNC_QUAL_EDGES 2048
`define SYNC_LOST_CYC 1000

// Hiccup
`define HICCUP_COUNT 128
`define HICCUP_WAIT_US 5500

// Reference and soft start
`define REF_TARGET 1000
`define REF_SS_PCT 90
`define TSS_US 3500
`define SOFT_START_RELEASE_US 5500
`define SS_STEP_CYC ((`TSS_US * 1000 / `CLK_NS) / (`REF_TARGET * `REF_SS_PCT / 100))
`define RECOV_MARGIN_DIV 100

// Bootstrap recharge (threshold 2.1 V is in the comparator)
`define BOOT_CHG_NS 200
`define BOOT_CHG_CYC ((`BOOT_CHG_NS + `CLK_NS - 1) / `CLK_NS)

// Register map
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_REF 8'h08
`define CTRL_FORCED_BIT 0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- rtl/buck_ctrl_pkg.sv
package buck_ctrl_pkg;

	// Converter sequencing states
	typedef enum logic [2:0] {
		ST_OFF,
		ST_SOFT,
		ST_RUN,
		ST_RECOVER,
		ST_HICCUP
	} state_e;

endpackage

//--- dv/switch_drv_model.sv
`timescale 1ns/1ns
// Stand-in for the switch drivers and the loop comparator behind them
module switch_drv_model (
	input wire logic sys_clk,
	input wire logic cycle_start,
	input wire logic upper_switch,
	input wire logic lower_switch,
	output logic pwm_on,
	output logic zero_cross,
	output int overlaps
);
	int on_cnt = 0;
	int low_cnt = 0;
	initial overlaps = 0;
	// On-time request after each cycle start; inductor drains while lower is on
	always @(posedge sys_clk) begin
		on_cnt <= cycle_start ? 40 : (on_cnt > 0 ? on_cnt - 1 : 0);
		low_cnt <= (lower_switch === 1'h1) ? low_cnt + 1 : 0;
		// Both switches on would short the input rail
		if (upper_switch === 1'h1 && lower_switch === 1'h1) begin
			overlaps <= overlaps + 1;
		end
	end
	assign pwm_on = on_cnt > 0;
	assign zero_cross = low_cnt > 30;
endmodule

//--- dv/buck_softstart_spread_ctrl_tb.sv
`timescale 1ns/1ns
`include "buck_ctrl_defines.svh"
module buck_softstart_spread_ctrl_tb;
	localparam int SPR = 5, LCK = 4, HIC = 3, SS = 2, FPM = 1, DE = 0;
	logic sys_clk = 0, nrst = 0, bootstrap_capacitor_node_low = 0, out_low = 0;
	logic out_below_40 = 0, dropout = 0, min_on_time = 0, light_load = 0, sync_edge = 0;
	logic in_regulation = 0, uvlo_ok = 1, en = 0, thermal_ok = 1;
	logic [9:0] out_level = 10'h3E8;
	logic pwm_on, zero_cross, upper_switch, lower_switch, cycle_start;
	logic [9:0] ref_code;
	logic diode_emulation, forced_pulse_width_mode, spread_active, clock_locked;
	logic hiccup_active, soft_start_active;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [31:0] d;
	int err_total = 0, checks = 0, overlaps, i, n, up, lo;
	int per [0:11];
	wire [5:0] flags = {spread_active, clock_locked, hiccup_active, soft_start_active,
		forced_pulse_width_mode, diode_emulation};

	buck_softstart_spread_ctrl #(.SOFT_START_RELEASE_CYC(2000), .HICCUP_WAIT_CYC(200))
		buck_softstart_spread_ctrl_inst (.sys_clk, .nrst, .bootstrap_capacitor_node_low,
		.out_low, .out_below_40, .dropout, .min_on_time, .light_load, .sync_edge,
		.in_regulation, .pwm_on, .zero_cross, .uvlo_ok, .en, .thermal_ok, .out_level,
		.upper_switch, .lower_switch, .cycle_start, .ref_code, .diode_emulation,
		.forced_pulse_width_mode, .spread_active, .clock_locked, .hiccup_active,
		.soft_start_active, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	switch_drv_model switch_drv_model_inst (.sys_clk, .cycle_start, .upper_switch,
		.lower_switch, .pwm_on, .zero_cross, .overlaps);

	// 100 MHz clock
	always #5 sys_clk = ~sys_clk;

	task automatic chk_eq(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_in(input logic [31:0] got, input int lo, input int hi);
		checks++;
		if ($isunknown(got) || got < lo || got > hi) begin
			err_total++;
			$display("wrong value at %0t: got %0d, expected %0d..%0d", $time, got, lo, hi);
		end
	endtask

	// Ready is sampled at the falling edge, so it is settled for the next rise
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] rs);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= wd;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do @(negedge sys_clk); while (!(s_axi_awready && s_axi_wready));
		@(posedge sys_clk);
		s_axi_awvalid <= 1'h0;
		s_axi_wvalid <= 1'h0;
		do @(negedge sys_clk); while (s_axi_bvalid !== 1'h1);
		@(posedge sys_clk);
		rs = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] rs);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(negedge sys_clk); while (s_axi_arready !== 1'h1);
		@(posedge sys_clk);
		s_axi_arvalid <= 1'h0;
		do @(negedge sys_clk); while (s_axi_rvalid !== 1'h1);
		@(posedge sys_clk);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask

	// Bounded wait for one status output to reach a level
	task automatic wait_flag(input int b, input logic v, input int lim);
		for (int k = 0; k < lim && flags[b] !== v; k++) @(negedge sys_clk);
		chk_eq(flags[b], v);
	endtask

	task automatic pulses(input int cnt);
		repeat (cnt) do @(negedge sys_clk); while (cycle_start !== 1'h1);
	endtask

	task automatic give_verdict;
		$display("checks %0d, mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Watchdog beyond the expected run of about 77k cycles
	initial begin
		#900000;
		err_total++;
		give_verdict;
	end

	initial begin
		repeat (8) @(posedge sys_clk);
		nrst <= 1'h1;
		@(negedge sys_clk);
		chk_eq({upper_switch, lower_switch, soft_start_active, spread_active}, 0);
		chk_eq(diode_emulation, 1);
		axi_rd(`ADDR_CTRL, d, r);
		chk_eq(d[0], 0);
		axi_rd(8'h0C, d, r);
		chk_eq(r, `RESP_SLVERR);
		axi_wr(8'h0C, 32'h1, r);
		chk_eq(r, `RESP_SLVERR);
		axi_wr(`ADDR_CTRL, 32'h1, r);
		axi_rd(`ADDR_CTRL, d, r);
		chk_eq(d[0], 1);
		$display("test registers done");
		// Enable starts a soft start in auto mode even with forced mode requested
		@(posedge sys_clk);
		en <= 1'h1;
		wait_flag(SS, 1, 20);
		chk_eq({forced_pulse_width_mode, diode_emulation}, 2'h1);
		repeat (1940) @(negedge sys_clk);
		chk_in(ref_code, 4, 6);
		@(posedge sys_clk);
		in_regulation <= 1'h1;
		wait_flag(SS, 0, 20);
		wait_flag(FPM, 1, 20);
		$display("test soft start done");
		// Boot undervoltage keeps the upper switch off, lower switch recharges
		@(posedge sys_clk);
		bootstrap_capacitor_node_low <= 1'h1;
		repeat (5) @(negedge sys_clk);
		up = 0;
		lo = 0;
		repeat (600) begin
			@(negedge sys_clk);
			up += upper_switch;
			lo += lower_switch;
		end
		chk_eq(up, 0);
		chk_in(lo, 1, 600);
		@(posedge sys_clk);
		bootstrap_capacitor_node_low <= 1'h0;
		$display("test boot recharge done");
		// Hopping periods stay in the band and move in small steps
		wait_flag(SPR, 1, 3000);
		for (i = 0; i < 12; i++) begin
			n = 0;
			do begin
				@(negedge sys_clk);
				n++;
			end while (cycle_start !== 1'h1);
			per[i] = n;
			if (i > 0) chk_in(per[i], 245, 255);
			if (i > 1) chk_in(per[i] - per[i-1] + 2, 0, 4);
		end
		// Dropout, minimum on-time, then auto-mode light load each stop hopping
		for (i = 0; i < 3; i++) begin
			if (i == 2) axi_wr(`ADDR_CTRL, 32'h0, r);
			@(posedge sys_clk);
			{dropout, min_on_time, light_load} <= 3'h4 >> i;
			wait_flag(SPR, 0, 3000);
			@(posedge sys_clk);
			{dropout, min_on_time, light_load} <= 3'h0;
			wait_flag(SPR, 1, 3000);
		end
		axi_wr(`ADDR_CTRL, 32'h1, r);
		light_load <= 1'h1;
		repeat (1100) @(negedge sys_clk);
		chk_eq(spread_active, 1);
		@(posedge sys_clk);
		light_load <= 1'h0;
		$display("test spread done");
		// External sync qualifies over 2048 rising edges
		for (i = 0; i < 2060; i++) begin
			@(posedge sys_clk);
			sync_edge <= 1'h1;
			repeat (5) @(posedge sys_clk);
			sync_edge <= 1'h0;
			repeat (4) @(posedge sys_clk);
			if (i == 2040) chk_eq(clock_locked, 0);
		end
		wait_flag(LCK, 1, 20);
		wait_flag(SPR, 0, 20);
		wait_flag(LCK, 0, 1500);
		wait_flag(SPR, 1, 3000);
		$display("test sync done");
		// Recovery: reference just above the output, forced mode kept
		@(posedge sys_clk);
		out_level <= 10'h1F4;
		out_low <= 1'h1;
		repeat (10) @(negedge sys_clk);
		axi_rd(`ADDR_STATUS, d, r);
		chk_eq(d[2:0], 3);
		chk_in(ref_code, 505, 506);
		chk_eq(forced_pulse_width_mode, 1);
		// A break in the low stretch restarts the hiccup count
		out_below_40 <= 1'h1;
		pulses(60);
		@(posedge sys_clk);
		out_below_40 <= 1'h0;
		pulses(3);
		@(posedge sys_clk);
		out_below_40 <= 1'h1;
		pulses(120);
		chk_eq(hiccup_active, 0);
		for (n = 120; n < 140 && hiccup_active !== 1'h1; n++) pulses(1);
		chk_in(n, 129, 131);
		chk_eq(hiccup_active, 1);
		@(posedge sys_clk);
		out_below_40 <= 1'h0;
		out_low <= 1'h0;
		out_level <= 10'h3E8;
		wait_flag(SS, 1, 400);
		chk_eq(overlaps, 0);
		$display("test recovery and hiccup done");
		give_verdict;
	end
endmodule
